// ### hdl/smst_pkg.sv
// shared types for the self-test sequencer
// assumes the constants header is included by every user
package smst_pkg;
  // sequencer states, one per test phase
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOGIC,
    ST_ANA1,
    ST_WAIT2,
    ST_ANA2,
    ST_DONE
  } smst_state_e;
  // duration in microsecond ticks
  typedef logic [12:0] smst_dur_t;
endpackage : smst_pkg

// ### hdl/smst_regs.svh
// register map, field positions, reset values and timing constants
// assumes a 32-bit word-aligned register bus and a 4 ns system clock
`ifndef SMST_REGS_SVH
`define SMST_REGS_SVH
// byte addresses of the register words
`define SMST_ADDR_W 8
`define SMST_ADDR_CTRL 8'h00
`define SMST_ADDR_STATUS 8'h04
`define SMST_ADDR_IRQ_STAT 8'h08
`define SMST_ADDR_IRQ_MASK 8'h0C
// control word: monitor selection for the post-init analog test
`define SMST_SEL_W 3
`define SMST_SEL_CORE 0
`define SMST_SEL_IO 1
`define SMST_SEL_AUX 2
`define SMST_SEL_RST 3'h0
// status word fields
`define SMST_ST_LOGIC_PASS 0
`define SMST_ST_ANA1_PASS 1
`define SMST_ST_ANA2_PASS 2
`define SMST_ST_FAIL 3
`define SMST_ST_BUSY 4
`define SMST_ST_DONE 5
// interrupt status and mask fields
`define SMST_IRQ_W 4
`define SMST_IRQ_LOGIC_DONE 0
`define SMST_IRQ_ANA1_DONE 1
`define SMST_IRQ_ANA2_DONE 2
`define SMST_IRQ_FAIL 3
`define SMST_IRQ_RST 4'h0
// timing: clock period, tick period, test durations in microseconds
`define SMST_CLK_PERIOD_NS 4
`define SMST_TICK_NS 1000
`define SMST_TICK_CYC (`SMST_TICK_NS / `SMST_CLK_PERIOD_NS)
`define SMST_LOGIC_TYP_US 4200
`define SMST_LOGIC_MAX_US 6000
`define SMST_ANA_MIN_US 200
`define SMST_ANA_MAX_US 1200
`define SMST_MON_CNT 3
`define SMST_ANA_STEP_US ((`SMST_ANA_MAX_US - `SMST_ANA_MIN_US) / `SMST_MON_CNT)
`define SMST_DUR_W 13
`endif

// ### hdl/smst_run_timer.sv
// down-counter timing one self-test run in ticks
// assumes start coincides with a tick divider clear
`timescale 1ns/1ps
module smst_run_timer
  import smst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire smst_dur_t load,
  input wire logic tick,
  output logic busy,
  output logic done
);
  smst_dur_t cnt_reg; // ticks left in the run
  // load on start, count ticks, pulse done at zero
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= load;
      busy <= 1'b1;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (busy && tick)
      begin
        cnt_reg <= cnt_reg - 1'b1;
        // last tick closes the run
        if (cnt_reg <= 13'h0001)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : smst_run_timer

// ### hdl/smst_sequencer.sv
// self-test sequencer of the fail-safe supervisor with APB registers
// assumes fault inputs from the test engines, and that the fail-safe
// state machine outside uses the release gates driven here
//
// Functional notes
// - logic test runs after reset and wake
// - logic fail: release resets, hold fail-safe low
// - logic pass flag readable by host
// - logic test within 6.0 ms, outputs wait
// - first analog test runs after reset, wake
// - first analog monitors come from OTP
// - second test waits init close, rails up
// - analog fail: release resets, hold fail-safe
// - separate readable pass flags per analog test
// - analog coverage; first test adds fixed checks
// - host selects monitors, default zero, reset clears
// - first analog test lasts 0.2 to 1.2 ms
// - second analog test lasts 0.2 to 1.2 ms
// - fail-safe release needs all three flags
`timescale 1ns/1ps
`include "smst_regs.svh"
module smst_sequencer
  import smst_pkg::*;
#(
  parameter int TICK_CYC = `SMST_TICK_CYC,
  parameter int LOGIC_TEST_US = `SMST_LOGIC_TYP_US,
  parameter int ANA_MIN_US = `SMST_ANA_MIN_US,
  parameter int ANA_STEP_US = `SMST_ANA_STEP_US
) (
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SMST_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fail-safe state machine side
  input wire logic wakeFromStandby,
  input wire logic safetyInitPhase,
  input wire logic initClosedGood,
  input wire logic [`SMST_SEL_W-1:0] otpFirstTestSel,
  // test engines
  input wire logic logicTestFault,
  input wire logic analogFault,
  input wire logic [`SMST_SEL_W-1:0] regStarted,
  input wire logic [`SMST_SEL_W-1:0] regAboveUv,
  output logic logicTestRun,
  output logic analogTestRun,
  output logic analogFixedChecks,
  output logic [`SMST_SEL_W-1:0] analogMonSel,
  // results
  output logic logicTestPassFlag,
  output logic startupAnalogPassFlag,
  output logic postInitAnalogPassFlag,
  output logic resetPgoodReleaseOk,
  output logic failsafeStuckLow,
  output logic failsafeReleaseOk,
  output logic irq
);

  // run length of an analog test from the number of monitors in it
  function automatic smst_dur_t analogDur(input logic [`SMST_SEL_W-1:0] sel);
    smst_dur_t n;
    n = '0;
    for (int i = 0; i < `SMST_SEL_W; i++)
    begin
      n = n + smst_dur_t'(sel[i]);
    end
    analogDur = smst_dur_t'(ANA_MIN_US) + smst_dur_t'(n * smst_dur_t'(ANA_STEP_US));
  endfunction : analogDur

  // ---- input synchronisers for analog comparator levels
  logic anaFaultMeta_reg; // first stage, read only by second
  logic anaFaultSync_reg; // usable fault level
  logic [`SMST_SEL_W-1:0] startedMeta_reg; // first stage
  logic [`SMST_SEL_W-1:0] startedSync_reg; // rails started
  logic [`SMST_SEL_W-1:0] aboveUvMeta_reg; // first stage
  logic [`SMST_SEL_W-1:0] aboveUvSync_reg; // rails above undervoltage

  // two flops on every level that comes from the analog domain
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      anaFaultMeta_reg <= 1'b0;
      anaFaultSync_reg <= 1'b0;
      startedMeta_reg <= '0;
      startedSync_reg <= '0;
      aboveUvMeta_reg <= '0;
      aboveUvSync_reg <= '0;
    end
    else
    begin
      anaFaultMeta_reg <= analogFault;
      anaFaultSync_reg <= anaFaultMeta_reg;
      startedMeta_reg <= regStarted;
      startedSync_reg <= startedMeta_reg;
      aboveUvMeta_reg <= regAboveUv;
      aboveUvSync_reg <= aboveUvMeta_reg;
    end
  end

  // ---- registers
  logic [`SMST_SEL_W-1:0] secondSel_reg; // host monitor selection
  logic [`SMST_IRQ_W-1:0] irqStat_reg; // sticky events
  logic [`SMST_IRQ_W-1:0] irqMask_reg; // event enables
  smst_state_e state_reg; // current phase
  smst_state_e state_next; // next phase
  logic faultSeen_reg; // fault seen in the current run
  logic failLatched_reg; // any failed test since reset
  logic [`SMST_SEL_W-1:0] firstSel_reg; // otp set held for the run

  // ---- apb decode
  logic apbSetup; // first cycle of a transfer
  logic apbAccess; // second cycle, the one that takes effect
  logic hitCtrl;
  logic hitStatus;
  logic hitIrqStat;
  logic hitIrqMask;
  logic hitAny;
  logic wrCtrl;
  logic wrIrqStat;
  logic wrIrqMask;
  assign apbSetup = psel && !penable;
  assign apbAccess = psel && penable;
  assign hitCtrl = (paddr == `SMST_ADDR_CTRL);
  assign hitStatus = (paddr == `SMST_ADDR_STATUS);
  assign hitIrqStat = (paddr == `SMST_ADDR_IRQ_STAT);
  assign hitIrqMask = (paddr == `SMST_ADDR_IRQ_MASK);
  assign hitAny = hitCtrl || hitStatus || hitIrqStat || hitIrqMask;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  // unmapped addresses answer with an error and read zero
  assign pslverr = apbAccess && !hitAny;
  assign wrCtrl = apbAccess && pwrite && hitCtrl;
  assign wrIrqStat = apbAccess && pwrite && hitIrqStat;
  assign wrIrqMask = apbAccess && pwrite && hitIrqMask;

  // ---- sequencer transitions
  logic timerDone; // run timer expired
  logic timerBusy; // run timer counting
  logic tick; // microsecond enable
  logic railsReady; // every selected rail started and above undervoltage
  logic enterLogic;
  logic enterAna1;
  logic enterAna2;
  logic startRun; // any test starts this cycle
  logic runDone; // any test finishes this cycle
  logic runFault; // fault input of the running test
  logic runFailed; // finishing test saw a fault
  smst_dur_t runLoad; // length of the starting run
  logic [`SMST_IRQ_W-1:0] irqEvent; // one-cycle events

  assign railsReady = ((secondSel_reg & ~(startedSync_reg & aboveUvSync_reg)) == '0);
  assign enterLogic = (state_reg == ST_IDLE) || wakeFromStandby;
  assign enterAna1 = (state_reg == ST_LOGIC) && timerDone && !wakeFromStandby;
  assign enterAna2 = (state_reg == ST_WAIT2) && initClosedGood && railsReady
    && !wakeFromStandby;
  assign startRun = enterLogic || enterAna1 || enterAna2;
  assign runDone = timerDone && !wakeFromStandby;
  assign runFault = (state_reg == ST_LOGIC) ? logicTestFault : anaFaultSync_reg;
  assign runFailed = runDone && (faultSeen_reg || runFault);

  assign runLoad = enterLogic ? smst_dur_t'(LOGIC_TEST_US)
    : enterAna1 ? analogDur(otpFirstTestSel) : analogDur(secondSel_reg);

  // next phase; a wake restarts the whole sequence from any phase
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_LOGIC;
      ST_LOGIC:
      begin
        if (timerDone)
        begin
          state_next = ST_ANA1;
        end
      end
      ST_ANA1:
      begin
        if (timerDone)
        begin
          state_next = ST_WAIT2;
        end
      end
      ST_WAIT2:
      begin
        if (enterAna2)
        begin
          state_next = ST_ANA2;
        end
      end
      ST_ANA2:
      begin
        if (timerDone)
        begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_DONE;
      default: state_next = ST_IDLE;
    endcase
    if (wakeFromStandby)
    begin
      state_next = ST_LOGIC;
    end
  end

  // phase register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // tick is realigned on each start so a run never ends short
  smst_tick_div #(
    .DIV(TICK_CYC)
  ) u_tick (
    .mclk(mclk),
    .rst(rst),
    .clear(startRun),
    .tick(tick)
  );

  // one shared timer serves all three tests, which never overlap
  smst_run_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .start(startRun),
    .load(runLoad),
    .tick(tick),
    .busy(timerBusy),
    .done(timerDone)
  );

  // fault memory of the current run and the permanent fail latch
  always_ff @(posedge mclk)
  begin
    if (rst || startRun)
    begin
      faultSeen_reg <= 1'b0;
    end
    else if (timerBusy && runFault)
    begin
      faultSeen_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      failLatched_reg <= 1'b0;
    end
    else if (runFailed)
    begin
      failLatched_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      firstSel_reg <= '0;
    end
    else if (enterAna1)
    begin
      firstSel_reg <= otpFirstTestSel;
    end
  end

  // pass flags: a wake clears all three since the sequence reruns
  always_ff @(posedge mclk)
  begin
    if (rst || enterLogic)
    begin
      logicTestPassFlag <= 1'b0;
      startupAnalogPassFlag <= 1'b0;
      postInitAnalogPassFlag <= 1'b0;
    end
    else
    begin
      if (runDone && state_reg == ST_LOGIC)
      begin
        logicTestPassFlag <= !runFailed;
      end
      if (enterAna2)
      begin
        postInitAnalogPassFlag <= 1'b0;
      end
      if (runDone && state_reg == ST_ANA1)
      begin
        startupAnalogPassFlag <= !runFailed;
      end
      if (runDone && state_reg == ST_ANA2)
      begin
        postInitAnalogPassFlag <= !runFailed;
      end
    end
  end

  // test engine controls, registered from the next phase
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      logicTestRun <= 1'b0;
      analogTestRun <= 1'b0;
      analogFixedChecks <= 1'b0;
      analogMonSel <= '0;
    end
    else
    begin
      logicTestRun <= (state_next == ST_LOGIC);
      analogTestRun <= (state_next == ST_ANA1) || (state_next == ST_ANA2);
      analogFixedChecks <= (state_next == ST_ANA1);
      analogMonSel <= (state_next == ST_ANA1) ? (enterAna1 ? otpFirstTestSel : firstSel_reg)
        : (state_next == ST_ANA2) ? secondSel_reg : '0;
    end
  end

  // release gates toward the fail-safe state machine
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      resetPgoodReleaseOk <= 1'b0;
      failsafeStuckLow <= 1'b0;
      failsafeReleaseOk <= 1'b0;
    end
    else
    begin
      resetPgoodReleaseOk <= (state_next == ST_WAIT2) || (state_next == ST_ANA2)
        || (state_next == ST_DONE);
      failsafeStuckLow <= failLatched_reg || runFailed;
      // all flags gate release
      // a restart drops release at once, on the same edge as the flags it clears
      failsafeReleaseOk <= logicTestPassFlag && startupAnalogPassFlag
        && postInitAnalogPassFlag && !failLatched_reg && !runFailed && !enterLogic;
    end
  end

  // host selection, reset clears
  // writes only count while the safety init phase is open
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      secondSel_reg <= `SMST_SEL_RST;
    end
    else if (wrCtrl && safetyInitPhase)
    begin
      secondSel_reg <= pwdata[`SMST_SEL_W-1:0];
    end
  end

  // events for the interrupt status
  assign irqEvent[`SMST_IRQ_LOGIC_DONE] = runDone && (state_reg == ST_LOGIC);
  assign irqEvent[`SMST_IRQ_ANA1_DONE] = runDone && (state_reg == ST_ANA1);
  assign irqEvent[`SMST_IRQ_ANA2_DONE] = runDone && (state_reg == ST_ANA2);
  assign irqEvent[`SMST_IRQ_FAIL] = runFailed;

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irqStat_reg <= `SMST_IRQ_RST;
    end
    else
    begin
      irqStat_reg <= (irqStat_reg & ~(wrIrqStat ? pwdata[`SMST_IRQ_W-1:0] : '0)) | irqEvent;
    end
  end

  // interrupt mask
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irqMask_reg <= `SMST_IRQ_RST;
    end
    else if (wrIrqMask)
    begin
      irqMask_reg <= pwdata[`SMST_IRQ_W-1:0];
    end
  end

  // level interrupt while any enabled event is pending
  assign irq = |(irqStat_reg & irqMask_reg);

  // read data, captured in the setup cycle and held through access
  logic [31:0] statusWord; // live status view
  logic [31:0] readMux; // selected register
  assign statusWord = {26'h0000000,
    (state_reg == ST_DONE),
    timerBusy,
    failLatched_reg,
    postInitAnalogPassFlag,
    startupAnalogPassFlag,
    logicTestPassFlag};
  assign readMux = hitCtrl ? {29'h00000000, secondSel_reg}
    : hitStatus ? statusWord
    : hitIrqStat ? {28'h0000000, irqStat_reg}
    : hitIrqMask ? {28'h0000000, irqMask_reg} : 32'h00000000;

  // read data register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
    end
    else if (apbSetup)
    begin
      prdata <= pwrite ? 32'h00000000 : readMux;
    end
  end

endmodule : smst_sequencer

// ### hdl/smst_tick_div.sv
// divider making a one-cycle microsecond tick enable
// assumes a single clock; clear realigns the tick to a test start
`timescale 1ns/1ps
module smst_tick_div #(
  parameter int DIV = 250
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_reg; // cycles within the current tick
  logic wrap; // last cycle of the tick period
  assign wrap = (cnt_reg == CW'(DIV - 1));
  // count cycles, pulse tick once per period
  always_ff @(posedge mclk)
  begin
    if (rst || clear)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      tick <= wrap;
    end
  end
endmodule : smst_tick_div

// ### tb/smst_engine_model.sv
// test engines and rails beside the sequencer
// assumes the bench commands faults and rail start-up
`timescale 1ns/1ps
module smst_engine_model (
  input wire logic mclk,
  input wire logic failLogic, // break the logic test
  input wire logic failAna, // break the analog tests
  input wire logic railsUp, // start the rails
  input wire logic logicTestRun,
  input wire logic analogTestRun,
  output logic logicTestFault,
  output logic analogFault,
  output logic [2:0] regStarted,
  output logic [2:0] regAboveUv
);
  logic [3:0] rampCnt = 4'h0; // rail ramp age
  // a fault shows only while its engine runs
  assign logicTestFault = failLogic && logicTestRun;
  assign analogFault = failAna && analogTestRun;
  // rails start, then cross undervoltage later
  assign regStarted = (rampCnt > 4'h3) ? 3'h7 : 3'h0;
  assign regAboveUv = (rampCnt > 4'h9) ? 3'h7 : 3'h0;
  // ramp saturates so rails stay up
  always @(posedge mclk)
  begin
    if (!railsUp)
      rampCnt <= 4'h0;
    else if (rampCnt != 4'hF)
      rampCnt <= rampCnt + 4'h1;
  end
endmodule : smst_engine_model

// ### tb/smst_sequencer_chk.sv
// port assertions for the self-test sequencer
// assumes the bind below and one clock with a synchronous reset
`timescale 1ns/1ps
`include "smst_regs.svh"
module smst_sequencer_chk
  import smst_pkg::*;
#(
  parameter int TICK_CYC = 4,
  parameter int LOGIC_TEST_US = 20,
  parameter int ANA_MIN_US = 5,
  parameter int ANA_STEP_US = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [`SMST_ADDR_W-1:0] paddr,
  input wire logic pslverr,
  input wire logic initClosedGood,
  input wire logic [`SMST_SEL_W-1:0] otpFirstTestSel,
  input wire logic logicTestRun,
  input wire logic analogTestRun,
  input wire logic analogFixedChecks,
  input wire logic [`SMST_SEL_W-1:0] analogMonSel,
  input wire logic logicTestPassFlag,
  input wire logic startupAnalogPassFlag,
  input wire logic postInitAnalogPassFlag,
  input wire logic failsafeStuckLow,
  input wire logic failsafeReleaseOk
);
  // longest runs in cycles; slack covers the tick realign
  localparam int LOGIC_MAX = LOGIC_TEST_US * TICK_CYC + 4;
  localparam int ANA_MAX = (ANA_MIN_US + 3 * ANA_STEP_US) * TICK_CYC + 4;
  logic [15:0] logicCnt_reg; // cycles of the running logic test
  logic [15:0] anaCnt_reg; // cycles of the running analog test
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // run counters restart whenever the run flag drops
  always_ff @(posedge mclk)
  begin
    logicCnt_reg <= (rst || !logicTestRun) ? 16'h0 : logicCnt_reg + 16'h1;
    anaCnt_reg <= (rst || !analogTestRun) ? 16'h0 : anaCnt_reg + 16'h1;
  end
  a_slverr_bad: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("no error on unmapped access");
  a_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  a_logic_start: assert property ($fell(rst) |-> ##[1:3] logicTestRun)
    else $error("logic test not started");
  a_logic_len: assert property (logicCnt_reg <= LOGIC_MAX)
    else $error("logic test too long");
  a_ana_len: assert property (anaCnt_reg <= ANA_MAX)
    else $error("analog test too long");
  a_otp_sel: assert property (analogFixedChecks |-> analogTestRun
    && analogMonSel == otpFirstTestSel)
    else $error("first test monitors wrong");
  a_ana2_gate: assert property ($rose(analogTestRun) && !analogFixedChecks
    |-> $past(initClosedGood))
    else $error("second test before init closed");
  a_stuck_hold: assert property (failsafeStuckLow |=> failsafeStuckLow)
    else $error("stuck low released");
  a_stuck_block: assert property (failsafeStuckLow |-> !failsafeReleaseOk)
    else $error("release after failure");
  a_release_flags: assert property (failsafeReleaseOk |-> logicTestPassFlag
    && startupAnalogPassFlag && postInitAnalogPassFlag)
    else $error("release without all flags");
  a_flag_clear: assert property ($rose(logicTestRun) |-> !logicTestPassFlag)
    else $error("flag kept at start");
  c_release: cover property ($rose(failsafeReleaseOk));
  c_stuck: cover property ($rose(failsafeStuckLow));
  c_slverr: cover property (psel && penable && pslverr);
endmodule : smst_sequencer_chk

bind smst_sequencer smst_sequencer_chk #(.TICK_CYC(TICK_CYC), .LOGIC_TEST_US(LOGIC_TEST_US),
  .ANA_MIN_US(ANA_MIN_US), .ANA_STEP_US(ANA_STEP_US)) i_chk (.mclk, .rst, .psel, .penable,
  .paddr, .pslverr, .initClosedGood, .otpFirstTestSel, .logicTestRun, .analogTestRun,
  .analogFixedChecks, .analogMonSel, .logicTestPassFlag, .startupAnalogPassFlag,
  .postInitAnalogPassFlag, .failsafeStuckLow, .failsafeReleaseOk);

// ### tb/smst_sequencer_tb.sv
// self-checking bench for the self-test sequencer
// assumes shortened run lengths and an APB master in this module
`timescale 1ns/1ps
module smst_sequencer_tb
  import smst_pkg::*;
;
  localparam int TICK = 4, LOGUS = 20, AMIN = 5, ASTEP = 3;
  logic mclk, rst, psel, penable, pwrite, wakeFromStandby, safetyInitPhase, initClosedGood;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, logicTestFault, analogFault, logicTestRun, analogTestRun;
  logic [2:0] otpFirstTestSel, regStarted, regAboveUv, analogMonSel, sel;
  logic analogFixedChecks, logicTestPassFlag, startupAnalogPassFlag, postInitAnalogPassFlag;
  logic resetPgoodReleaseOk, failsafeStuckLow, failsafeReleaseOk, irq, failLogic, failAna;
  logic railsUp;
  logic [31:0] expQ[$]; // read data still to come
  int errors, checked, n, e2;
  int cyc = 0; // edges seen, updated non-blocking
  int mark; // edge count at the start of the current measurement
  smst_sequencer #(.TICK_CYC(TICK), .LOGIC_TEST_US(LOGUS), .ANA_MIN_US(AMIN),
    .ANA_STEP_US(ASTEP)) i_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wakeFromStandby, .safetyInitPhase, .initClosedGood,
    .otpFirstTestSel, .logicTestFault, .analogFault, .regStarted, .regAboveUv, .logicTestRun,
    .analogTestRun, .analogFixedChecks, .analogMonSel, .logicTestPassFlag,
    .startupAnalogPassFlag, .postInitAnalogPassFlag, .resetPgoodReleaseOk, .failsafeStuckLow,
    .failsafeReleaseOk, .irq);
  smst_engine_model i_eng (.mclk, .failLogic, .failAna, .railsUp, .logicTestRun,
    .analogTestRun, .logicTestFault, .analogFault, .regStarted, .regAboveUv);
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one APB transfer; a read notes its expected data for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      expQ.push_back(d);
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    // one idle edge, so a following call never re-assigns psel in one step
    @(posedge mclk);
  endtask : apb
  function automatic logic pick(input int k);
    case (k)
      0: return logicTestPassFlag;
      1: return resetPgoodReleaseOk;
      2: return postInitAnalogPassFlag;
      3: return failsafeStuckLow;
      default: return analogTestRun;
    endcase
  endfunction : pick
  // waits for a result; n is the edges since the last mark, the watchdog bounds it
  task automatic upto(input int k);
    while (pick(k) !== 1'b1)
    begin
      @(posedge mclk);
    end
    n = cyc - mark;
    mark = cyc;
  endtask : upto
  initial
  begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  // edge count; non-blocking so every reader at an edge sees the old count
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
  end
  // read data is judged at the edge that completes the access
  always @(posedge mclk)
  begin
    if (psel && penable && !pwrite && pready)
      chk("prdata", expQ.pop_front(), prdata);
  end
  // watchdog well past the expected run
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    stop_test();
  end
  initial
  begin
    {rst, psel, penable, pwrite, wakeFromStandby, initClosedGood} = 6'h20;
    {failLogic, failAna, railsUp, paddr, pwdata} = 43'h0;
    {safetyInitPhase, otpFirstTestSel} = 4'hF;
    {errors, checked} = 0;
    void'($urandom(32'h974CE7BE));
    repeat (3) @(posedge mclk);
    rst <= 0;
    // the logic run is timed from the reset release, not from the first call
    mark = cyc;
    @(posedge mclk);
    apb(0, 8'h00, 32'h0);
    apb(0, 8'h0C, 32'h0);
    apb(0, 8'h10, 32'h0);
    sel = 3'($urandom % 7) + 3'h1;
    apb(1, 8'h00, {29'h0, sel});
    apb(0, 8'h00, {29'h0, sel});
    upto(0);
    chk("logic time", 1, n >= LOGUS * TICK - 6 && n <= LOGUS * TICK + 6);
    chk("fixed checks", 1, analogFixedChecks);
    chk("first sel", 7, analogMonSel);
    upto(1);
    e2 = (AMIN + 3 * ASTEP) * TICK;
    chk("first time", 1, n >= e2 - 2 && n <= e2 + 6);
    @(posedge mclk);
    chk("first pass", 1, startupAnalogPassFlag);
    safetyInitPhase <= 0;
    apb(1, 8'h00, 32'h0);
    apb(0, 8'h00, {29'h0, sel});
    initClosedGood <= 1;
    repeat (8) @(posedge mclk);
    chk("second wait", 0, analogTestRun);
    railsUp <= 1;
    upto(4);
    upto(2);
    e2 = (AMIN + ASTEP * $countones(sel)) * TICK;
    chk("second time", 1, n >= e2 - 2 && n <= e2 + 6);
    repeat (2) @(posedge mclk);
    chk("release ok", 1, failsafeReleaseOk);
    apb(0, 8'h04, 32'h27);
    apb(0, 8'h08, 32'h7);
    apb(1, 8'h0C, 32'h4);
    @(posedge mclk);
    chk("irq on", 1, irq);
    apb(1, 8'h08, 32'h4);
    @(posedge mclk);
    chk("irq off", 0, irq);
    failLogic <= 1;
    wakeFromStandby <= 1;
    @(posedge mclk);
    wakeFromStandby <= 0;
    @(posedge mclk);
    chk("flag cleared", 0, postInitAnalogPassFlag);
    chk("release dropped", 0, failsafeReleaseOk);
    chk("reset release wait", 0, resetPgoodReleaseOk);
    upto(3);
    upto(1);
    @(posedge mclk);
    chk("logic pass", 0, logicTestPassFlag);
    chk("release blocked", 0, failsafeReleaseOk);
    rst <= 1;
    failLogic <= 0;
    failAna <= 1;
    repeat (3) @(posedge mclk);
    rst <= 0;
    upto(0);
    upto(1);
    repeat (4) @(posedge mclk);
    chk("first pass", 0, startupAnalogPassFlag);
    chk("stuck", 1, failsafeStuckLow);
    apb(0, 8'h00, 32'h0);
    stop_test();
  end
endmodule : smst_sequencer_tb
